/* File: hdl/ppt_pkg.sv */
// constants and carrier types for the bidirectional printer port
// assumes a byte-wide i/o register port with a 16-bit address
package ppt_pkg;

	// ---------------------------------------------------------------
	// register block placement
	// ---------------------------------------------------------------
	localparam logic [15:0] BASE_PRIMARY   = 16'h0378;
	localparam logic [15:0] BASE_SECONDARY = 16'h0278;
	localparam int          BLOCK_BITS     = 3;

	localparam logic [2:0] OFS_DATA     = 3'h0;
	localparam logic [2:0] OFS_STATUS   = 3'h1;
	localparam logic [2:0] OFS_CONTROL  = 3'h2;
	localparam logic [2:0] OFS_IRQ_STAT = 3'h3;
	localparam logic [2:0] OFS_IRQ_MASK = 3'h4;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int CTL_STROBE_BIT     = 0;
	localparam int CTL_LINE_FEED_BIT  = 1;
	localparam int CTL_PRN_RESET_BIT  = 2;
	localparam int CTL_SELECT_BIT     = 3;
	localparam int CTL_IRQ_EN_BIT     = 4;
	localparam int STAT_FAULT_BIT     = 3;
	localparam int STAT_ONLINE_BIT    = 4;
	localparam int STAT_MEDIA_BIT     = 5;
	localparam int STAT_ACK_BIT       = 6;
	localparam int STAT_BUSY_BIT      = 7;
	localparam int IRQ_ACK_EDGE_BIT   = 0;

	// control bits whose pin is the inverse of the written bit
	localparam logic [3:0] CTL_INV_MASK = 4'hB;
	// constant upper control bits and lower status bits
	localparam logic [2:0] CTL_FILL     = 3'h7;
	localparam logic [2:0] STAT_FILL    = 3'h7;

	// ---------------------------------------------------------------
	// values after reset and bus answers
	// ---------------------------------------------------------------
	localparam logic [7:0] DATA_RST       = 8'h00;
	localparam logic [3:0] CTL_LINES_RST  = 4'h0;
	localparam logic       CTL_IRQ_EN_RST = 1'b0;
	localparam logic [7:0] IRQ_STAT_RST   = 8'h00;
	localparam logic [7:0] IRQ_MASK_RST   = 8'h00;
	localparam logic [7:0] RDATA_IDLE     = 8'h00;
	localparam logic [7:0] RDATA_UNMAPPED = 8'hFF;

	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic busy_n;
		logic ack;
		logic media_out;
		logic online;
		logic fault_n;
	} ppt_status_pins_t;

	typedef struct packed {
		logic select_req_n;
		logic printer_reset_n;
		logic line_feed_after_n;
		logic strobe_n;
	} ppt_ctl_pins_t;

	typedef struct packed {
		logic port_enable;
		logic use_secondary;
	} ppt_strap_t;

endpackage

/* File: hdl/ppt_sync.sv */
// two flip-flop synchroniser for a group of slow external levels
// assumes the inputs may change at any time relative to mclk
`timescale 1ns/10ps

module ppt_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             mclk,  // system clock
	input  wire logic [WIDTH-1:0] d,     // asynchronous levels
	output logic      [WIDTH-1:0] q      // levels on mclk
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] q_reg;
	logic [WIDTH-1:0] q_next;

	// ---------------------------------------------------------------
	// stages
	// ---------------------------------------------------------------
	// first stage is read only by the second
	always_comb begin
		meta_next = d;
		q_next    = meta_reg;
	end

	// no reset: the stages settle within two edges
	always_ff @(posedge mclk) begin
		meta_reg <= meta_next;
		q_reg    <= q_next;
	end

	assign q = q_reg;

endmodule

/* File: hdl/ppt_port.sv */
// bidirectional printer port: data, status and control registers,
// open-drain control lines, reversible data lines, ack interrupt
// assumes a single-cycle i/o strobe port on mclk and slow pins
`timescale 1ns/10ps

module ppt_port (
	input  wire logic                      mclk,        // 100 MHz clock
	input  wire logic                      reset,       // sync, high
	// strap pins
	input  wire ppt_pkg::ppt_strap_t       strap,       // enable, base
	// register port
	input  wire logic [15:0]               io_addr,     // i/o address
	input  wire logic [7:0]                io_wdata,    // write data
	input  wire logic                      io_wr,       // write strobe
	input  wire logic                      io_rd,       // read strobe
	output logic      [7:0]                io_rdata,    // read data
	output logic                           io_claim,    // rdata valid
	// interrupt
	output logic                           irq7,        // level irq
	// data lines
	input  wire logic                      data_direction_in, // 1: in
	input  wire logic [7:0]                data_in,     // pin levels
	output logic      [7:0]                data_out,    // drive value
	output logic                           data_oe,     // drive enable
	// open-drain control lines
	input  wire ppt_pkg::ppt_ctl_pins_t    ctl_in,      // pin levels
	output ppt_pkg::ppt_ctl_pins_t         ctl_out,     // pull value
	output ppt_pkg::ppt_ctl_pins_t         ctl_oe,      // pull enable
	// status lines
	input  wire ppt_pkg::ppt_status_pins_t status_in    // pin levels
);

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	localparam int SYNC_W = 8 + 4 + 5 + 1 + 2;

	logic [SYNC_W-1:0]          sync_d;
	logic [SYNC_W-1:0]          sync_q;
	logic [7:0]                 data_pins;
	ppt_pkg::ppt_ctl_pins_t     ctl_pins;
	ppt_pkg::ppt_status_pins_t  stat_pins;
	logic                       dir_in;
	ppt_pkg::ppt_strap_t        strap_pins;

	// every outside level passes two flops before use
	assign sync_d = {data_in, ctl_in, status_in, data_direction_in,
		strap};

	ppt_sync #(
		.WIDTH (SYNC_W)
	) u_sync (
		.mclk  (mclk),
		.d     (sync_d),
		.q     (sync_q)
	);

	assign data_pins  = sync_q[19:12];
	assign ctl_pins   = sync_q[11:8];
	assign stat_pins  = sync_q[7:3];
	assign dir_in     = sync_q[2];
	assign strap_pins = sync_q[1:0];

	// ---------------------------------------------------------------
	// strap capture
	// ---------------------------------------------------------------
	logic        strap_taken_reg;
	logic        strap_taken_next;
	logic        port_en_reg;
	logic        port_en_next;
	logic        secondary_reg;
	logic        secondary_next;
	logic [15:0] base;

	// straps are caught once, on the first edge after reset release
	always_comb begin
		strap_taken_next = strap_taken_reg;
		port_en_next     = port_en_reg;
		secondary_next   = secondary_reg;
		if (reset) begin
			strap_taken_next = 1'b0;
			port_en_next     = 1'b0;
			secondary_next   = 1'b0;
		end else if (!strap_taken_reg) begin
			strap_taken_next = 1'b1;
			port_en_next     = strap_pins.port_enable;
			secondary_next   = strap_pins.use_secondary;
		end
	end

	always_ff @(posedge mclk) begin
		strap_taken_reg <= strap_taken_next;
		port_en_reg     <= port_en_next;
		secondary_reg   <= secondary_next;
	end

	// base follows the strap, nothing else can move it
	assign base = secondary_reg ? ppt_pkg::BASE_SECONDARY
		: ppt_pkg::BASE_PRIMARY;

	// ---------------------------------------------------------------
	// address decode
	// ---------------------------------------------------------------
	logic       hit;
	logic [2:0] ofs;
	logic       wr_hit;
	logic       rd_hit;

	// a disabled port never matches, leaving the range to others
	assign hit = port_en_reg && (io_addr[15:ppt_pkg::BLOCK_BITS]
		== base[15:ppt_pkg::BLOCK_BITS]);
	assign ofs    = io_addr[ppt_pkg::BLOCK_BITS-1:0];
	assign wr_hit = hit && io_wr;
	assign rd_hit = hit && io_rd;

	// ---------------------------------------------------------------
	// data and control registers
	// ---------------------------------------------------------------
	logic [7:0] data_reg;
	logic [7:0] data_next;
	logic [3:0] ctl_lines_reg;
	logic [3:0] ctl_lines_next;
	logic       irq_en_reg;
	logic       irq_en_next;

	// status offset is not in the write case, so its writes drop
	always_comb begin
		data_next      = data_reg;
		ctl_lines_next = ctl_lines_reg;
		irq_en_next    = irq_en_reg;
		if (reset) begin
			data_next      = ppt_pkg::DATA_RST;
			ctl_lines_next = ppt_pkg::CTL_LINES_RST;
			irq_en_next    = ppt_pkg::CTL_IRQ_EN_RST;
		end else if (wr_hit) begin
			case (ofs)
				ppt_pkg::OFS_DATA: begin
					data_next = io_wdata;
				end
				ppt_pkg::OFS_CONTROL: begin
					ctl_lines_next = io_wdata[3:0];
					irq_en_next    =
						io_wdata[ppt_pkg::CTL_IRQ_EN_BIT];
				end
				default: begin
					data_next = data_reg;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		data_reg      <= data_next;
		ctl_lines_reg <= ctl_lines_next;
		irq_en_reg    <= irq_en_next;
	end

	// ---------------------------------------------------------------
	// data line drivers
	// ---------------------------------------------------------------
	logic [7:0] data_out_reg;
	logic [7:0] data_out_next;
	logic       data_oe_reg;
	logic       data_oe_next;

	// direction low drives the register, high lets the pins float
	always_comb begin
		data_out_next = data_reg;
		data_oe_next  = ~dir_in;
		if (reset) begin
			data_out_next = ppt_pkg::DATA_RST;
			data_oe_next  = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		data_out_reg <= data_out_next;
		data_oe_reg  <= data_oe_next;
	end

	assign data_out = data_out_reg;
	assign data_oe  = data_oe_reg;

	// ---------------------------------------------------------------
	// open-drain control lines
	// ---------------------------------------------------------------
	logic [3:0] ctl_level;
	logic [3:0] ctl_oe_reg;
	logic [3:0] ctl_oe_next;
	logic [3:0] ctl_out_reg;
	logic [3:0] ctl_read;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_ctl
			// wanted pin level from bit and polarity
			assign ctl_level[gi] = ctl_lines_reg[gi]
				^ ppt_pkg::CTL_INV_MASK[gi];
			// read back the pin with the written polarity
			assign ctl_read[gi] = ctl_pins[gi]
				^ ppt_pkg::CTL_INV_MASK[gi];
		end
	endgenerate

	// pull low only where level 0 is wanted; else release high
	always_comb begin
		ctl_oe_next = ~ctl_level;
		if (reset) begin
			ctl_oe_next = ~(ppt_pkg::CTL_LINES_RST
				^ ppt_pkg::CTL_INV_MASK);
		end
	end

	// the driver only ever sinks, so its value stays low
	always_ff @(posedge mclk) begin
		ctl_oe_reg  <= ctl_oe_next;
		ctl_out_reg <= 4'h0;
	end

	assign ctl_oe  = ctl_oe_reg;
	assign ctl_out = ctl_out_reg;

	// ---------------------------------------------------------------
	// acknowledge edge and interrupt status
	// ---------------------------------------------------------------
	logic       ack_prev_reg;
	logic       ack_prev_next;
	logic       ack_rise;
	logic [7:0] irq_stat_reg;
	logic [7:0] irq_stat_next;
	logic [7:0] irq_mask_reg;
	logic [7:0] irq_mask_next;
	logic [7:0] irq_set;
	logic [7:0] irq_clr;
	logic       irq7_reg;
	logic       irq7_next;

	// edge is counted only while the enable bit is high
	assign ack_rise = stat_pins.ack && !ack_prev_reg
		&& irq_en_reg && port_en_reg;
	assign irq_set = {7'h00, ack_rise};
	assign irq_clr = (wr_hit && (ofs == ppt_pkg::OFS_IRQ_STAT))
		? io_wdata : 8'h00;

	// sticky bits: a new event beats a same-cycle clear
	always_comb begin
		ack_prev_next = stat_pins.ack;
		irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;
		irq_mask_next = irq_mask_reg;
		if (wr_hit && (ofs == ppt_pkg::OFS_IRQ_MASK)) begin
			irq_mask_next = io_wdata;
		end
		// no interrupt from a disabled port or with bit 4 low
		irq7_next = port_en_reg && irq_en_reg
			&& |(irq_stat_reg & irq_mask_reg);
		if (reset) begin
			ack_prev_next = 1'b1;
			irq_stat_next = ppt_pkg::IRQ_STAT_RST;
			irq_mask_next = ppt_pkg::IRQ_MASK_RST;
			irq7_next     = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		ack_prev_reg <= ack_prev_next;
		irq_stat_reg <= irq_stat_next;
		irq_mask_reg <= irq_mask_next;
		irq7_reg     <= irq7_next;
	end

	assign irq7 = irq7_reg;

	// ---------------------------------------------------------------
	// read path
	// ---------------------------------------------------------------
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic       claim_reg;
	logic       claim_next;
	logic [7:0] status_word;
	logic [7:0] control_word;
	logic [7:0] data_word;

	// status pins read straight, low three bits fixed at one
	assign status_word = {stat_pins.busy_n, stat_pins.ack,
		stat_pins.media_out, stat_pins.online, stat_pins.fault_n,
		ppt_pkg::STAT_FILL};
	assign control_word = {ppt_pkg::CTL_FILL, irq_en_reg,
		ctl_read};
	// input mode returns the pins, output mode the register
	assign data_word = dir_in ? data_pins : data_reg;

	// data stands for the one cycle after the read strobe
	always_comb begin
		rdata_next = ppt_pkg::RDATA_IDLE;
		claim_next = 1'b0;
		if (rd_hit && !reset) begin
			claim_next = 1'b1;
			case (ofs)
				ppt_pkg::OFS_DATA: begin
					rdata_next = data_word;
				end
				ppt_pkg::OFS_STATUS: begin
					rdata_next = status_word;
				end
				ppt_pkg::OFS_CONTROL: begin
					rdata_next = control_word;
				end
				ppt_pkg::OFS_IRQ_STAT: begin
					rdata_next = irq_stat_reg;
				end
				ppt_pkg::OFS_IRQ_MASK: begin
					rdata_next = irq_mask_reg;
				end
				default: begin
					rdata_next = ppt_pkg::RDATA_UNMAPPED;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		rdata_reg <= rdata_next;
		claim_reg <= claim_next;
	end

	assign io_rdata = rdata_reg;
	assign io_claim = claim_reg;

endmodule

/* File: sim/ppt_port_asserts.sv */
// checker for the printer port, watching only its ports
// assumes a bind from the bench top file
`timescale 1ns/10ps

module ppt_port_asserts (
	input wire logic                      mclk,      // clock
	input wire logic                      reset,     // sync reset
	input wire ppt_pkg::ppt_strap_t       strap,     // straps
	input wire logic [15:0]               io_addr,   // address
	input wire logic [7:0]                io_wdata,  // write data
	input wire logic                      io_wr,     // write strobe
	input wire logic                      io_rd,     // read strobe
	input wire logic [7:0]                io_rdata,  // read data
	input wire logic                      io_claim,  // answered
	input wire logic                      irq7,      // interrupt
	input wire logic                      data_direction_in, // dir
	input wire logic [7:0]                data_in,   // data pins
	input wire logic [7:0]                data_out,  // data drive
	input wire logic                      data_oe,   // data enable
	input wire ppt_pkg::ppt_ctl_pins_t    ctl_in,    // ctl pins
	input wire ppt_pkg::ppt_ctl_pins_t    ctl_out,   // ctl sink
	input wire ppt_pkg::ppt_ctl_pins_t    ctl_oe,    // ctl enable
	input wire ppt_pkg::ppt_status_pins_t status_in  // status pins
);
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	logic       ack_d;
	logic [3:0] age_reg;
	logic [3:0] age_next;
	wire logic  hit = strap.port_enable && io_addr[15:3] ==
		(strap.use_secondary ? ppt_pkg::BASE_SECONDARY[15:3]
		: ppt_pkg::BASE_PRIMARY[15:3]);

	// cycles since the raw ack pin rose, saturating
	always_comb begin
		age_next = (age_reg == 4'hF) ? age_reg : age_reg + 4'h1;
		if (status_in.ack && !ack_d)
			age_next = 4'h0;
	end
	always_ff @(posedge mclk) begin
		ack_d   <= reset ? 1'b1 : status_in.ack;
		age_reg <= reset ? 4'hF : age_next;
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	property ctl_follow;
		logic [3:0] v;
		(io_wr && hit && io_addr[2:0] == ppt_pkg::OFS_CONTROL,
		 v = io_wdata[3:0]) |-> ##2 ctl_oe == ~(v ^ ppt_pkg::CTL_INV_MASK);
	endproperty

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	rd_answer_a: assert property (io_rd && hit |=> io_claim)
		else $error("read in range not answered");
	foreign_addr_a: assert property (io_rd && !hit |=>
		!io_claim && io_rdata == ppt_pkg::RDATA_IDLE)
		else $error("foreign read answered");
	disabled_quiet_a: assert property (!strap.port_enable |->
		!io_claim && !irq7) else $error("disabled port active");
	ctl_write_a: assert property (ctl_follow)
		else $error("control lines do not follow write");
	ctl_sink_a: assert property (ctl_out == 4'h0)
		else $error("control line driven high");
	status_fill_a: assert property (io_rd && hit &&
		io_addr[2:0] == ppt_pkg::OFS_STATUS |=>
		io_rdata[2:0] == ppt_pkg::STAT_FILL)
		else $error("status low bits not ones");
	drive_out_a: assert property (
		!data_direction_in [*5] |-> data_oe)
		else $error("data lines not driven");
	release_in_a: assert property (
		data_direction_in [*5] |-> !data_oe)
		else $error("data lines not released");
	irq_clear_a: assert property (io_wr && hit && io_wdata[0] &&
		io_addr[2:0] == ppt_pkg::OFS_IRQ_STAT |-> ##2 !irq7)
		else $error("interrupt not cleared");
	irq_cause_a: assert property ($rose(irq7) |->
		age_reg <= 4'h6) else $error("interrupt without ack edge");

	cover property (io_claim);
	cover property ($rose(irq7));
	cover property ($fell(data_oe));
endmodule

/* File: sim/ppt_printer_model.sv */
// far end of the printer port: wires, pull-ups, outside driver
// assumes the bench sets what the far end drives
`timescale 1ns/10ps

module ppt_printer_model (
	input  wire logic                   mclk,      // clock
	input  wire logic [7:0]             data_out,  // device value
	input  wire logic                   data_oe,   // device drives
	input  wire ppt_pkg::ppt_ctl_pins_t ctl_out,   // sink value
	input  wire ppt_pkg::ppt_ctl_pins_t ctl_oe,    // sink enable
	input  wire logic                   ext_drive, // far end drives
	input  wire logic [7:0]             ext_data,  // far end data
	input  wire logic [3:0]             ext_pull,  // far end sinks
	output logic      [7:0]             data_in,   // data wire
	output ppt_pkg::ppt_ctl_pins_t      ctl_in,    // ctl wire
	output logic                        dir_in     // direction pin
);
	logic [7:0] last_reg = 8'h00;

	// undriven data lines toggle so stale values never pass
	always @(posedge mclk)
		last_reg <= data_in;
	always_comb begin
		if (data_oe)
			data_in = data_out;
		else if (ext_drive)
			data_in = ext_data;
		else
			data_in = ~last_reg;
	end

	// pull-ups: a line is low only while someone sinks it
	assign ctl_in = ppt_pkg::ppt_ctl_pins_t'(
		~((ctl_oe & ~ctl_out) | ext_pull));
	assign dir_in = ctl_in.printer_reset_n;
endmodule

/* File: sim/ppt_port_tb.sv */
// self-checking bench for the printer port
// assumes the port, printer model and checker are compiled first
`timescale 1ns/10ps

module ppt_port_tb;
	localparam logic [15:0] P = ppt_pkg::BASE_PRIMARY;
	logic                      mclk = 1'b0;
	logic                      reset = 1'b1;
	ppt_pkg::ppt_strap_t       strap = 2'b10;
	logic [15:0]               io_addr = 16'h0000;
	logic [7:0]                io_wdata = 8'h00;
	logic                      io_wr = 1'b0;
	logic                      io_rd = 1'b0;
	logic [7:0]                io_rdata, data_in, data_out, rd_val;
	logic                      io_claim, irq7, dir_in, data_oe, rd_ok;
	logic                      ext_drive = 1'b0;
	logic [7:0]                ext_data = 8'h00;
	logic [3:0]                ext_pull = 4'h0;
	ppt_pkg::ppt_ctl_pins_t    ctl_in, ctl_out, ctl_oe;
	ppt_pkg::ppt_status_pins_t status_in = 5'b10110;
	int                        errors = 0;
	int                        n_compared = 0;

	ppt_port uut (.mclk, .reset, .strap, .io_addr, .io_wdata, .io_wr,
		.io_rd, .io_rdata, .io_claim, .irq7, .data_direction_in(dir_in),
		.data_in, .data_out, .data_oe, .ctl_in, .ctl_out, .ctl_oe,
		.status_in);
	ppt_printer_model mdl (.mclk, .data_out, .data_oe, .ctl_out, .ctl_oe,
		.ext_drive, .ext_data, .ext_pull, .data_in, .ctl_in, .dir_in);

	// 100 MHz clock
	always #5 mclk = ~mclk;

	// ---------------------------------------------------------------
	// bus and check tasks
	// ---------------------------------------------------------------
	task automatic chk(input string w, input logic [7:0] e, g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("FAIL %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		io_addr <= a;
		io_wdata <= d;
		io_wr <= 1'b1;
		@(posedge mclk);
		io_wr <= 1'b0;
	endtask
	// read, then check data and whether the port answered
	task automatic rdx(input string w, input logic [15:0] a,
		input logic [7:0] e, input logic c);
		@(posedge mclk);
		io_addr <= a;
		io_rd <= 1'b1;
		@(posedge mclk);
		io_rd <= 1'b0;
		#1;
		rd_val = io_rdata;
		rd_ok = io_claim;
		chk(w, e, rd_val);
		chk("claim", {7'h0, c}, {7'h0, rd_ok});
	endtask
	task automatic do_reset(input ppt_pkg::ppt_strap_t s);
		@(posedge mclk);
		reset <= 1'b1;
		strap <= s;
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_regs;
		rdx("control reset", P + 16'h0002, 8'hE0, 1'b1);
		rdx("data reset", P, 8'h00, 1'b1);
		rdx("status", P + 16'h0001, {status_in, 3'b111}, 1'b1);
		wr(P + 16'h0001, 8'h00);
		rdx("status kept", P + 16'h0001, {status_in, 3'b111}, 1'b1);
		rdx("unmapped", P + 16'h0005, 8'hFF, 1'b1);
		rdx("foreign", 16'h0478, 8'h00, 1'b0);
		rdx("other base", 16'h027A, 8'h00, 1'b0);
		$display("test regs done");
	endtask
	task automatic t_data;
		wr(P, 8'hA5);
		cyc(2);
		chk("data pins", 8'hA5, data_out);
		chk("data enable", 8'h01, {7'h0, data_oe});
		rdx("data back", P, 8'hA5, 1'b1);
		wr(P + 16'h0002, 8'h04);
		ext_drive <= 1'b1;
		ext_data <= 8'h3C;
		cyc(8);
		chk("data released", 8'h00, {7'h0, data_oe});
		rdx("data input", P, 8'h3C, 1'b1);
		wr(P + 16'h0002, 8'h00);
		ext_drive <= 1'b0;
		cyc(8);
		chk("data driven", 8'h01, {7'h0, data_oe});
		$display("test data done");
	endtask
	task automatic t_ctl;
		logic [3:0] v;
		for (int i = 0; i < 4; i++) begin
			v = 4'h1 << i;
			wr(P + 16'h0002, {4'h0, v});
			cyc(3);
			chk("control sink", {4'h0, ~(v ^ 4'hB)}, {4'h0, ctl_oe});
			rdx("control back", P + 16'h0002, {4'hE, v}, 1'b1);
		end
		wr(P + 16'h0002, 8'h04);
		ext_pull <= 4'h9;
		cyc(4);
		rdx("control input", P + 16'h0002, {4'hE, 4'h6 ^ 4'hB}, 1'b1);
		@(posedge mclk);
		ext_pull <= 4'h0;
		$display("test control done");
	endtask
	task automatic t_irq;
		wr(P + 16'h0004, 8'h01);
		wr(P + 16'h0002, 8'h10);
		status_in.ack <= 1'b1;
		cyc(8);
		chk("irq raised", 8'h01, {7'h0, irq7});
		rdx("irq status", P + 16'h0003, 8'h01, 1'b1);
		// a cleared mask drops the line while the status stays set
		wr(P + 16'h0004, 8'h00);
		cyc(2);
		chk("irq masked", 8'h00, {7'h0, irq7});
		rdx("irq mask", P + 16'h0004, 8'h00, 1'b1);
		// clear, then unmask: a stuck status bit would raise it again
		wr(P + 16'h0003, 8'h01);
		wr(P + 16'h0004, 8'h01);
		cyc(2);
		chk("irq cleared", 8'h00, {7'h0, irq7});
		@(posedge mclk);
		status_in.ack <= 1'b0;
		wr(P + 16'h0002, 8'h00);
		status_in.ack <= 1'b1;
		cyc(8);
		chk("irq off", 8'h00, {7'h0, irq7});
		rdx("irq none", P + 16'h0003, 8'h00, 1'b1);
		@(posedge mclk);
		status_in.ack <= 1'b0;
		$display("test irq done");
	endtask
	task automatic t_straps;
		do_reset(2'b11);
		rdx("second base", 16'h027A, 8'hE0, 1'b1);
		rdx("first off", P + 16'h0002, 8'h00, 1'b0);
		do_reset(2'b00);
		rdx("disabled", P + 16'h0001, 8'h00, 1'b0);
		wr(P + 16'h0004, 8'h01);
		wr(P + 16'h0002, 8'h10);
		status_in.ack <= 1'b1;
		cyc(8);
		chk("disabled irq", 8'h00, {7'h0, irq7});
		$display("test straps done");
	endtask

	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		repeat (3) @(posedge mclk);
		t_regs;
		t_data;
		t_ctl;
		t_irq;
		t_straps;
		end_of_test;
	end

	// watchdog: the tests need about 160 cycles
	initial begin
		repeat (4000) @(posedge mclk);
		errors++;
		$display("FAIL watchdog expected done seen running");
		end_of_test;
	end
endmodule

bind ppt_port ppt_port_asserts u_chk (.mclk, .reset, .strap, .io_addr,
	.io_wdata, .io_wr, .io_rd, .io_rdata, .io_claim, .irq7,
	.data_direction_in, .data_in, .data_out, .data_oe, .ctl_in,
	.ctl_out, .ctl_oe, .status_in);
